// ==== include/adsq_map.vh ====
// Register map, field positions and reset values of the converter sequencer
`ifndef ADSQ_MAP_VH
`define ADSQ_MAP_VH
`define ADSQ_BASE_HI 20'h4000B
`define ADSQ_UNITS 3
`define ADSQ_OFS_MODE 8'h00
`define ADSQ_OFS_CHAN 8'h04
`define ADSQ_OFS_CLKSMP 8'h08
`define ADSQ_OFS_TRG0 8'h0C
`define ADSQ_OFS_TRG1 8'h10
`define ADSQ_OFS_TRG2 8'h14
`define ADSQ_OFS_BURST 8'h18
`define ADSQ_OFS_STARTSTOP 8'h20
`define ADSQ_OFS_STATUS 8'h24
`define ADSQ_OFS_IE 8'h28
`define ADSQ_OFS_DMADATA 8'h2C
`define ADSQ_OFS_CMP 8'h70
`define ADSQ_MODE_MASK 32'hFF0317BF
`define ADSQ_CLKSMP_RST 16'h0080
`define ADSQ_CLKSMP_MASK 16'hFFFF
`define ADSQ_STATUS_MASK 32'h00000003
// Mode register fields
`define ADSQ_F_WAIT_HI 31
`define ADSQ_F_WAIT_LO 24
`define ADSQ_F_DMA_REQUEST_ENABLE 17
`define ADSQ_F_TAGPOS 16
`define ADSQ_F_WAITEN 12
`define ADSQ_F_BLEN_HI 10
`define ADSQ_F_BLEN_LO 8
`define ADSQ_F_CONVEN 7
`define ADSQ_F_MODE_HI 5
`define ADSQ_F_MODE_LO 4
`define ADSQ_F_TRIGGER_ENABLE 3
`define ADSQ_F_TSRC_HI 2
`define ADSQ_F_TSRC_LO 0
`define ADSQ_MODE_SINGLE 2'h0
`define ADSQ_MODE_CONT 2'h1
`define ADSQ_MODE_BURST 2'h3
// Clock and sample control fields
`define ADSQ_F_DIV_HI 14
`define ADSQ_F_DIV_LO 8
`define ADSQ_F_PDOWN 7
`define ADSQ_F_STIME_HI 4
`define ADSQ_F_STIME_LO 0
`define ADSQ_STIME_ON 5'h1F
`define ADSQ_SAMP_MIN 6'h02
// Start and stop bits
`define ADSQ_F_START 0
`define ADSQ_F_STOP 4
// Status bits, busy is read only
`define ADSQ_S_EOC 0
`define ADSQ_S_BURST 1
`define ADSQ_S_BUSY 8
// Trigger source codes
`define ADSQ_TSRC_MAX 3'h5
`endif

// ==== tb/adsq_chk.sv ====
// Port-level protocol and sequencing checks for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adsq_chk (
   input wire clk_i,
   input wire nrst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   input wire [2:0] dma_done_i,
   input wire [2:0] conv_start_o,
   input wire [2:0] sample_o,
   input wire [2:0] dma_req_o,
   input wire [2:0] irq_o,
   input wire [2:0] power_down_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_answer;
      !pready_o ##1 pready_o;
   endsequence
   a_ready_late: assert property (s_setup ##1 (psel_i && penable_i) |-> s_answer)
      else $error("ready not in second access cycle");
   a_ready_once: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   a_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error answer malformed");
   a_start_pulse: assert property (conv_start_o[0] |=> !conv_start_o[0])
      else $error("start pulse too long");
   a_window_min: assert property ($rose(sample_o[0]) |-> sample_o[0][*2])
      else $error("sample window under two ticks");
   a_start_sampled: assert property (conv_start_o[0] |-> $past(sample_o[0]))
      else $error("conversion without sample window");
   a_dma_hold: assert property (dma_req_o[0] && !dma_done_i[0] |=> dma_req_o[0])
      else $error("dma request dropped early");
   a_dma_release: assert property (dma_req_o[0] && dma_done_i[0] |=> !dma_req_o[0])
      else $error("dma request not released");
   a_irq_after_dma: assert property ($rose(irq_o[0]) |-> !dma_req_o[0])
      else $error("interrupt before dma done");
   a_pdown_write: assert property ($changed(power_down_o) |-> $past(pready_o && pwrite_i))
      else $error("power down changed without write");
endmodule
bind adsq_ctrl adsq_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .dma_done_i(dma_done_i), .conv_start_o(conv_start_o), .sample_o(sample_o), .dma_req_o(dma_req_o),
   .irq_o(irq_o), .power_down_o(power_down_o));
`default_nettype wire

// ==== tb/adsq_conv_model.sv ====
// Behavioural converter cores and DMA controller facing the three units
`timescale 1ns/1ps
`default_nettype none
module adsq_conv_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic slow_i,
   input wire logic [11:0] res_i,
   input wire logic [2:0] conv_start_i,
   input wire logic [2:0] dma_req_i,
   output logic [2:0] conv_done_o,
   output logic [35:0] conv_result_o,
   output logic [2:0] dma_done_o
);
   logic [3:0] cc [3];
   logic [3:0] dc [3];
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         conv_done_o <= 3'h0;
         dma_done_o <= 3'h0;
         conv_result_o <= 36'h5A5A5A5A5;
         for (int u = 0; u < 3; u++) begin
            cc[u] <= 4'h0;
            dc[u] <= 4'h0;
         end
      end else begin
         for (int u = 0; u < 3; u++) begin
            conv_done_o[u] <= 1'b0;
            dma_done_o[u] <= 1'b0;
            // Result lines toggle outside the valid cycle so stale data never matches
            conv_result_o[12*u+:12] <= ~conv_result_o[12*u+:12];
            if (cc[u] == 4'h1) begin
               conv_done_o[u] <= 1'b1;
               conv_result_o[12*u+:12] <= res_i;
            end
            cc[u] <= conv_start_i[u] ? (slow_i ? 4'h9 : 4'h2) : ((cc[u] != 4'h0) ? cc[u] - 4'h1 : 4'h0);
            if (dma_req_i[u] && dc[u] == 4'h0 && !dma_done_o[u]) begin
               dc[u] <= slow_i ? 4'h7 : 4'h2;
            end else if (dc[u] > 4'h1) begin
               dc[u] <= dc[u] - 4'h1;
            end else if (dc[u] == 4'h1) begin
               dma_done_o[u] <= dma_req_i[u];
               dc[u] <= 4'h0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/adsq_ctrl_tb.sv ====
// Self-checking bench for the three-unit converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adsq_map.vh"
module adsq_ctrl_tb;
   logic clk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, slow = 0, e;
   logic [31:0] paddr = 0, pwdata = 0, prdata, r, bs, lf = 32'd77490;
   logic pready, pslverr;
   logic [2:0] tmr = 0, cs, smp, dreq, irq, pd, done, ddone;
   logic [1:0] pwm = 0;
   logic [11:0] chn, res = 0;
   logic [35:0] cres;
   logic [7:0] w;
   logic [3:0] c;
   logic [7:0] ofs [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h70};
   int err_total = 0, n_compared = 0, cyc = 0, s, f, nc, nd, t0;
   int d [2];
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc <= cyc + 1;
   adsq_ctrl DUT (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .trig_pin_i(pin), .timer_trig_i(tmr), .pwm_trig_i(pwm), .conv_done_i(done), .conv_result_i(cres),
      .dma_done_i(ddone), .conv_start_o(cs), .conv_channel_o(chn), .sample_o(smp), .dma_req_o(dreq),
      .irq_o(irq), .power_down_o(pd));
   adsq_conv_model PM (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .res_i(res), .conv_start_i(cs),
      .dma_req_i(dreq), .conv_done_o(done), .conv_result_o(cres), .dma_done_o(ddone));
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [31:0] dword(input logic tg, input logic [3:0] ch, input logic [11:0] v);
      return tg ? {16'h0, v, ch} : {12'h0, ch, 4'h0, v};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic final_report;
      $display("compared=%0d mismatches=%0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dt);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= dt;
      @(posedge clk_i);
      penable <= 1;
      do begin @(posedge clk_i); n++; end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
      chk(n < 20, 1);
   endtask
   task automatic wr(input int u, input logic [7:0] o, input logic [31:0] dt);
      apb(1, {`ADSQ_BASE_HI, u[3:0], o}, dt);
   endtask
   task automatic rd(input int u, input logic [7:0] o, input logic [31:0] x);
      apb(0, {`ADSQ_BASE_HI, u[3:0], o}, 0);
      chk(r, x);
   endtask
   // Waits for the next start pulse, counting sample-window cycles before it
   task automatic conv;
      int n;
      n = 0; s = 0;
      while (cs[0] !== 1'b1 && n < 400) begin @(posedge clk_i); n++; s += (smp[0] === 1'b1); end
      c = chn[3:0];
      chk(n < 400, 1);
      @(posedge clk_i);
   endtask
   task automatic wt(input int dm);
      int n;
      n = 0;
      do begin @(posedge clk_i); n++; end while ((dm ? ddone[0] : done[0]) !== 1'b1 && n < 200);
      chk(n < 200, 1);
   endtask
   task automatic quiet(input int n);
      nc = 0; nd = 0;
      repeat (n) begin @(posedge clk_i); nc += (cs[0] === 1'b1); nd += (done[0] === 1'b1); end
   endtask
   task automatic tup(input int t);
      @(posedge clk_i);
      if (t == 0) pin <= 1; else if (t < 4) tmr[t-1] <= 1; else pwm[t-4] <= 1;
   endtask
   initial begin
      #1000000;
      err_total++;
      final_report;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      nrst_i <= 1;
      chk(pd, 3'h7);
      foreach (ofs[i]) for (int u = 0; u < 3; u++) rd(u, ofs[i], ofs[i] == 8'h08 ? 32'h80 : 32'h0);
      for (int u = 0; u < 3; u++) begin
         lf = nx(lf);
         wr(u, 8'h0C, lf); rd(u, 8'h0C, lf);
         wr(u, 8'h04, lf); rd(u, 8'h04, lf & 32'hF);
         wr(u, 8'h00, lf & ~32'h80); rd(u, 8'h00, lf & ~32'h80 & `ADSQ_MODE_MASK);
         wr(u, 8'h00, 0); wr(u, 8'h2C, lf); rd(u, 8'h2C, 0);
         apb(0, {`ADSQ_BASE_HI, u[3:0], 8'h34}, 0); chk(e, 1);
      end
      apb(1, 32'h4000_B300, 1); chk(e, 1);
      for (int ch = 0; ch < 16; ch++) begin
         lf = nx(lf); res <= lf[27:16]; f = lf[2:0];
         wr(0, 8'h08, f); wr(0, 8'h00, 32'h80 | (ch % 2) << 16); wr(0, 8'h04, ch); wr(0, 8'h20, 1);
         conv; chk(s, 2 + f);
         chk(c, ch);
         wt(0); rd(0, 8'h2C, dword(ch % 2, ch, res));
      end
      chk(irq[0], 0); wr(0, 8'h28, 1); repeat (2) @(posedge clk_i); chk(irq[0], 1);
      rd(0, 8'h24, 1); wr(0, 8'h24, 1); repeat (2) @(posedge clk_i); chk(irq[0], 0);
      wr(0, 8'h00, 0); wr(0, 8'h20, 1); quiet(30); chk(nc, 0);
      rd(0, 8'h20, 0);
      lf = nx(lf); bs = lf; w = lf[31:24] | 8'h1; wr(0, 8'h18, bs);
      for (int k = 0; k < 2; k++) begin
         wr(0, 8'h00, {w, 6'h0, 1'b1, 1'b0, 3'h0, k[0], 1'b0, 3'h7, 8'hB0}); wr(0, 8'h20, 1); t0 = cyc;
         for (int j = 0; j < 8; j++) begin
            conv; chk(c, bs[4*j+:4]);
            if (j == 0) chk(irq[0], 0);
            if (j == 7) d[k] = cyc - t0;
            wt(1);
         end
         quiet(300); chk(nc, 0);
         rd(0, 8'h24, 3); wr(0, 8'h24, 3);
      end
      chk(d[1] - d[0], 7 * w);
      slow <= 1; wr(0, 8'h04, 5); wr(0, 8'h00, 32'h98); wr(0, 8'h20, 1);
      for (int j = 0; j < 3; j++) begin conv; chk(c, 5); end
      tup(0); wr(0, 8'h20, 32'h10); quiet(60); chk(nc, 0);
      chk(nd, 1);
      pin <= 0; slow <= 0; wr(0, 8'h04, 9);
      for (int t = 0; t < 6; t++) begin
         wr(0, 8'h00, 32'h88 | t); tup(t); conv; chk(c, 9);
         wt(0); pin <= 0; tmr <= 0; pwm <= 0;
      end
      wr(0, 8'h00, 32'h81); tup(1); quiet(30); chk(nc, 0);
      wr(0, 8'h08, 32'h1F); repeat (2) @(posedge clk_i); chk(smp[0], 1);
      final_report;
   end
endmodule
`default_nettype wire

// ==== verilog/adsq_ctrl.v ====
// Converter sequencer control: three units behind one APB slave
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "adsq_map.vh"

// One converter unit: registers, master clock divider and conversion sequencer
module adsq_unit (
   input wire clk_i,
   input wire nrst_i,
   input wire wr_i,
   input wire [7:0] ofs_i,
   input wire [31:0] wdata_i,
   output reg [31:0] rdata_o,
   output reg hit_o,
   input wire [5:0] trig_lvl_i,
   input wire conv_done_i,
   input wire [11:0] conv_result_i,
   input wire dma_done_i,
   output reg conv_start_o,
   output reg [3:0] conv_channel_o,
   output reg sample_o,
   output reg dma_req_o,
   output reg irq_o,
   output wire power_down_o
);
   localparam ST_IDLE = 6'h01;
   localparam ST_WAIT = 6'h02;
   localparam ST_SAMP = 6'h04;
   localparam ST_CONV = 6'h08;
   localparam ST_DMA = 6'h10;
   localparam ST_NEXT = 6'h20;
   reg [31:0] mode_reg;
   reg [3:0] chan_num_reg;
   reg [15:0] clksmp_reg;
   reg [31:0] trg0_reg;
   reg [31:0] trg1_reg;
   reg [31:0] trg2_reg;
   reg [31:0] burst_reg;
   reg [31:0] cmp_reg;
   reg start_reg;
   reg stop_reg;
   reg stop_pend_reg;
   reg [31:0] status_reg;
   reg [31:0] ie_reg;
   reg [31:0] data_reg;
   reg [5:0] state_reg;
   reg [6:0] div_reg;
   reg [5:0] samp_reg;
   reg [7:0] wait_reg;
   reg [2:0] slot_reg;
   reg [5:0] trig_prev_reg;
   reg set_eoc;
   reg set_burst;
   wire [7:0] wait_count = mode_reg[`ADSQ_F_WAIT_HI:`ADSQ_F_WAIT_LO];
   wire dma_en = mode_reg[`ADSQ_F_DMA_REQUEST_ENABLE];
   wire tag_low = mode_reg[`ADSQ_F_TAGPOS];
   wire wait_en = mode_reg[`ADSQ_F_WAITEN];
   wire [2:0] burst_len = mode_reg[`ADSQ_F_BLEN_HI:`ADSQ_F_BLEN_LO];
   wire conv_en = mode_reg[`ADSQ_F_CONVEN];
   wire [1:0] conv_mode = mode_reg[`ADSQ_F_MODE_HI:`ADSQ_F_MODE_LO];
   wire trig_en = mode_reg[`ADSQ_F_TRIGGER_ENABLE];
   wire [2:0] tsrc = mode_reg[`ADSQ_F_TSRC_HI:`ADSQ_F_TSRC_LO];
   wire [6:0] div = clksmp_reg[`ADSQ_F_DIV_HI:`ADSQ_F_DIV_LO];
   wire [4:0] stime = clksmp_reg[`ADSQ_F_STIME_HI:`ADSQ_F_STIME_LO];
   wire is_burst = (conv_mode == `ADSQ_MODE_BURST);
   wire is_cont = (conv_mode == `ADSQ_MODE_CONT);
   wire is_single = (conv_mode == `ADSQ_MODE_SINGLE);
   // Divide 0 runs at the system clock, divide 1 stops the master clock
   wire mtick = (div == 7'h00) || ((div != 7'h01) && (div_reg == div - 7'h01));
   wire [5:0] samp_last = `ADSQ_SAMP_MIN + {1'b0, stime} - 6'h01;
   wire [5:0] trig_rise = trig_lvl_i & ~trig_prev_reg;
   // Reserved source codes never fire
   wire trig_hit = (tsrc <= `ADSQ_TSRC_MAX) && trig_rise[tsrc];
   wire trig_go = trig_en && conv_en && (is_single || is_burst) && trig_hit;
   wire start_go = start_reg && mtick && conv_en;
   wire [3:0] slot0_ch = burst_reg[3:0];
   wire [3:0] first_ch = is_burst ? slot0_ch : chan_num_reg;
   wire [2:0] slot_nx = slot_reg + 3'h1;
   wire [3:0] slot_nx_ch = burst_reg[{slot_nx, 2'b00} +: 4];
   wire [31:0] status_clr = (wr_i && (ofs_i == `ADSQ_OFS_STATUS)) ? wdata_i : 32'h00000000;
   wire [31:0] status_set = {30'h0, set_burst, set_eoc};
   assign power_down_o = clksmp_reg[`ADSQ_F_PDOWN];
   // Register read path and mapped-offset decode
   always @* begin
      hit_o = 1'b1;
      case (ofs_i)
         `ADSQ_OFS_MODE: rdata_o = mode_reg;
         `ADSQ_OFS_CHAN: rdata_o = {28'h0, chan_num_reg};
         `ADSQ_OFS_CLKSMP: rdata_o = {16'h0, clksmp_reg};
         `ADSQ_OFS_TRG0: rdata_o = trg0_reg;
         `ADSQ_OFS_TRG1: rdata_o = trg1_reg;
         `ADSQ_OFS_TRG2: rdata_o = trg2_reg;
         `ADSQ_OFS_BURST: rdata_o = burst_reg;
         `ADSQ_OFS_STARTSTOP: rdata_o = {31'h0, start_reg};
         `ADSQ_OFS_STATUS: rdata_o = status_reg | {23'h0, ~state_reg[0], 8'h00};
         `ADSQ_OFS_IE: rdata_o = ie_reg;
         `ADSQ_OFS_DMADATA: rdata_o = data_reg;
         `ADSQ_OFS_CMP: rdata_o = cmp_reg;
         default: begin
            rdata_o = 32'h00000000;
            hit_o = 1'b0;
         end
      endcase
   end
   // Configuration registers; the data register has no write path
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_reg <= 32'h00000000;
         chan_num_reg <= 4'h0;
         clksmp_reg <= `ADSQ_CLKSMP_RST;
         trg0_reg <= 32'h00000000;
         trg1_reg <= 32'h00000000;
         trg2_reg <= 32'h00000000;
         burst_reg <= 32'h00000000;
         cmp_reg <= 32'h00000000;
         ie_reg <= 32'h00000000;
      end else if (wr_i) begin
         case (ofs_i)
            `ADSQ_OFS_MODE: mode_reg <= wdata_i & `ADSQ_MODE_MASK;
            `ADSQ_OFS_CHAN: chan_num_reg <= wdata_i[3:0];
            `ADSQ_OFS_CLKSMP: clksmp_reg <= wdata_i[15:0] & `ADSQ_CLKSMP_MASK;
            `ADSQ_OFS_TRG0: trg0_reg <= wdata_i;
            `ADSQ_OFS_TRG1: trg1_reg <= wdata_i;
            `ADSQ_OFS_TRG2: trg2_reg <= wdata_i;
            `ADSQ_OFS_BURST: burst_reg <= wdata_i;
            `ADSQ_OFS_IE: ie_reg <= wdata_i & `ADSQ_STATUS_MASK;
            `ADSQ_OFS_CMP: cmp_reg <= wdata_i;
            default: cmp_reg <= cmp_reg;
         endcase
      end
   end
   // Start and stop bits self-clear on the next master clock tick
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else if (wr_i && (ofs_i == `ADSQ_OFS_STARTSTOP)) begin
         start_reg <= wdata_i[`ADSQ_F_START];
         stop_reg <= wdata_i[`ADSQ_F_STOP];
      end else if (mtick) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end
   end
   // Master clock divider and trigger edge history
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_reg <= 7'h00;
         trig_prev_reg <= 6'h00;
      end else begin
         div_reg <= mtick ? 7'h00 : div_reg + 7'h01;
         trig_prev_reg <= trig_lvl_i;
      end
   end
   // Sticky status: a hardware set in the clearing cycle survives
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_reg <= 32'h00000000;
         irq_o <= 1'b0;
      end else begin
         status_reg <= ((status_reg & ~status_clr) | status_set) & `ADSQ_STATUS_MASK;
         irq_o <= |(status_reg & ie_reg);
      end
   end
   // Event strobes into the status register
   always @* begin
      set_eoc = 1'b0;
      set_burst = 1'b0;
      if (state_reg == ST_CONV && conv_done_i && !dma_en) begin
         set_eoc = 1'b1;
      end
      if (state_reg == ST_DMA && dma_done_i) begin
         set_eoc = 1'b1;
      end
      if (state_reg == ST_NEXT && is_burst && (slot_reg == burst_len)) begin
         set_burst = 1'b1;
      end
   end
   // Conversion sequencer
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= ST_IDLE;
         samp_reg <= 6'h00;
         wait_reg <= 8'h00;
         slot_reg <= 3'h0;
         stop_pend_reg <= 1'b0;
         conv_start_o <= 1'b0;
         conv_channel_o <= 4'h0;
         sample_o <= 1'b0;
         dma_req_o <= 1'b0;
         data_reg <= 32'h00000000;
      end else begin
         conv_start_o <= 1'b0;
         if (stop_reg && !state_reg[0]) begin
            stop_pend_reg <= 1'b1;
         end
         if (!conv_en) begin
            // Disabling abandons the sequence at once
            state_reg <= ST_IDLE;
            sample_o <= 1'b0;
            dma_req_o <= 1'b0;
            stop_pend_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  stop_pend_reg <= 1'b0;
                  // An all-ones sample field holds the sampling switch closed
                  sample_o <= (stime == `ADSQ_STIME_ON);
                  if ((start_go || trig_go) && !stop_reg) begin
                     slot_reg <= 3'h0;
                     conv_channel_o <= first_ch;
                     samp_reg <= 6'h00;
                     sample_o <= 1'b1;
                     state_reg <= ST_SAMP;
                  end
               end
               ST_WAIT: begin
                  if (stop_pend_reg) begin
                     state_reg <= ST_IDLE;
                  end else if (mtick) begin
                     if (wait_reg == wait_count - 8'h01) begin
                        samp_reg <= 6'h00;
                        sample_o <= 1'b1;
                        state_reg <= ST_SAMP;
                     end
                     wait_reg <= wait_reg + 8'h01;
                  end
               end
               ST_SAMP: begin
                  if (mtick) begin
                     if (samp_reg == samp_last) begin
                        sample_o <= (stime == `ADSQ_STIME_ON);
                        conv_start_o <= 1'b1;
                        state_reg <= ST_CONV;
                     end
                     samp_reg <= samp_reg + 6'h01;
                  end
               end
               ST_CONV: begin
                  if (conv_done_i) begin
                     if (tag_low) begin
                        data_reg <= {16'h0, conv_result_i, conv_channel_o};
                     end else begin
                        data_reg <= {12'h0, conv_channel_o, 4'h0, conv_result_i};
                     end
                     if (dma_en) begin
                        dma_req_o <= 1'b1;
                        state_reg <= ST_DMA;
                     end else begin
                        state_reg <= ST_NEXT;
                     end
                  end
               end
               ST_DMA: begin
                  if (dma_done_i) begin
                     dma_req_o <= 1'b0;
                     state_reg <= ST_NEXT;
                  end
               end
               ST_NEXT: begin
                  if (is_burst && (slot_reg != burst_len) && !stop_pend_reg) begin
                     slot_reg <= slot_nx;
                     conv_channel_o <= slot_nx_ch;
                     wait_reg <= 8'h00;
                     samp_reg <= 6'h00;
                     if (wait_en && (wait_count != 8'h00)) begin
                        state_reg <= ST_WAIT;
                     end else begin
                        sample_o <= 1'b1;
                        state_reg <= ST_SAMP;
                     end
                  end else if (is_cont && !stop_pend_reg && !stop_reg) begin
                     conv_channel_o <= chan_num_reg;
                     samp_reg <= 6'h00;
                     sample_o <= 1'b1;
                     state_reg <= ST_SAMP;
                  end else begin
                     state_reg <= ST_IDLE;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end
endmodule

module adsq_ctrl (
   input wire clk_i,
   input wire nrst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire trig_pin_i,
   input wire [2:0] timer_trig_i,
   input wire [1:0] pwm_trig_i,
   input wire [2:0] conv_done_i,
   input wire [35:0] conv_result_i,
   input wire [2:0] dma_done_i,
   output wire [2:0] conv_start_o,
   output wire [11:0] conv_channel_o,
   output wire [2:0] sample_o,
   output wire [2:0] dma_req_o,
   output wire [2:0] irq_o,
   output wire [2:0] power_down_o
);
   reg [2:0] pin_sync_reg;
   reg pin_lvl_reg;
   wire [1:0] unit_idx = paddr_i[9:8];
   wire base_ok = (paddr_i[31:12] == `ADSQ_BASE_HI) && (paddr_i[11:10] == 2'b00)
      && (paddr_i[1:0] == 2'b00) && (unit_idx < `ADSQ_UNITS);
   wire access = psel_i && penable_i;
   wire commit = access && pready_o;
   wire [31:0] rdata_u [0:2];
   wire [2:0] hit_u;
   wire [5:0] trig_lvl = {pwm_trig_i, timer_trig_i, pin_lvl_reg};

   // The pin level only changes once the last two stages agree
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_sync_reg <= 3'b000;
         pin_lvl_reg <= 1'b0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], trig_pin_i};
         if (pin_sync_reg[1] == pin_sync_reg[2]) begin
            pin_lvl_reg <= pin_sync_reg[2];
         end
      end
   end

   // One wait state lets read data come from a flop; writes land on the final edge
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h00000000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= access && !pready_o;
         if (access && !pready_o) begin
            pslverr_o <= !(base_ok && hit_u[unit_idx]);
            prdata_o <= (base_ok && !pwrite_i) ? rdata_u[unit_idx] : 32'h00000000;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

   genvar u;
   generate
      for (u = 0; u < `ADSQ_UNITS; u = u + 1) begin : g_unit
         adsq_unit unit_inst (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .wr_i(commit && pwrite_i && base_ok && (unit_idx == u)),
            .ofs_i(paddr_i[7:0]),
            .wdata_i(pwdata_i),
            .rdata_o(rdata_u[u]),
            .hit_o(hit_u[u]),
            .trig_lvl_i(trig_lvl),
            .conv_done_i(conv_done_i[u]),
            .conv_result_i(conv_result_i[12*u +: 12]),
            .dma_done_i(dma_done_i[u]),
            .conv_start_o(conv_start_o[u]),
            .conv_channel_o(conv_channel_o[4*u +: 4]),
            .sample_o(sample_o[u]),
            .dma_req_o(dma_req_o[u]),
            .irq_o(irq_o[u]),
            .power_down_o(power_down_o[u])
         );
      end
   endgenerate
endmodule
`default_nettype wire
